// File: cpmc_defines.svh
// constants for the clock path mode configuration block
// assumes register offsets are word indices on the plain register port
`ifndef CPMC_DEFINES_SVH
`define CPMC_DEFINES_SVH
`define CPMC_ADDR_W        10
`define CPMC_OFF_PLL       10'h010
`define CPMC_OFF_CAL       10'h018
`define CPMC_OFF_VDIV      10'h1e0
`define CPMC_OFF_PATH      10'h1e1
`define CPMC_OFF_XFER      10'h232
`define CPMC_OFF_NVM       10'h3f0
`define CPMC_OFF_STAT      10'h3f1
`define CPMC_PWR_LSB       0
`define CPMC_POL_BIT       7
`define CPMC_BYP_BIT       0
`define CPMC_SRC_BIT       1
`define CPMC_CAL_BIT       0
`define CPMC_XFER_BIT      0
`define CPMC_NVM_SAVE_BIT  0
`define CPMC_NVM_LOAD_BIT  1
`define CPMC_PWR_RST       2'h1
`define CPMC_PWR_RUN       2'h0
`define CPMC_VDIV_RST      3'h0
`define CPMC_CAL_NS        4000
`define CPMC_CAL_CYC       ((`CPMC_CAL_NS + 39) / 40)
`endif

// File: cpmc_pkg.sv
// types shared by the clock path mode configuration block
package cpmc_pkg;
  typedef struct packed {
    logic [1:0] pwr;
    logic       pol;
    logic       cal;
    logic [2:0] vdiv;
    logic       byp;
    logic       src;
  } cpmc_cfg_s;
  typedef enum logic [1:0] {CPMC_IDLE, CPMC_SAVE, CPMC_LOAD} cpmc_nvm_e;
endpackage

// File: cpmc_store_if.sv
// carries configuration between the top and its nonvolatile store
`timescale 1ns/10ps
interface cpmc_store_if;
  import cpmc_pkg::*;
  logic      save;
  logic      load;
  cpmc_cfg_s wdata;
  cpmc_cfg_s rdata;
  logic      valid;
  modport ctl (output save, output load, output wdata,
               input rdata, input valid);
  modport mem (input save, input load, input wdata,
               output rdata, output valid);
endinterface

// File: cpmc_store.sv
// nonvolatile configuration store model, one configuration word
// assumes it keeps contents across resets of the top
`timescale 1ns/10ps
`include "cpmc_defines.svh"
module cpmc_store (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  cpmc_store_if.mem st
);
  import cpmc_pkg::*;
  cpmc_cfg_s mem;
  logic      written = 1'b0;
  // contents and the written flag survive resets of the top, so a saved
  // configuration comes back at every power-up; no save while in reset
  always_ff @(posedge clk_sys_i) begin
    if (rstn_i && st.save) begin
      mem     <= st.wdata;
      written <= 1'b1;
    end
  end
  assign st.rdata = mem;
  assign st.valid = written;
endmodule

// File: cpmc_top.sv
// clock path mode configuration: shadow and active registers, update
// strobe, calibration start, nonvolatile save and restore
// assumes host follows the calibrate clear-then-set sequence
// Operation
// - power field 00 runs, 01 powers down
// - source bit 1 selects internal VCO
// - bypass bit 1 skips VCO divider
// - reset defaults: PLL off, CLK, divider used
// - polarity bit selects positive or negative
// - calibrate bit plus update starts calibration when internal VCO source selected
// - internal VCO off when CLK source used
// - configuration saved and restored from storage
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "cpmc_defines.svh"
module cpmc_top #(
  parameter int CAL_CYC = `CPMC_CAL_CYC
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rstn_i,
  input  wire logic [`CPMC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  output logic      [1:0]             pll_pwr_o,
  output logic                        pll_on_o,
  output logic                        pfd_neg_o,
  output logic                        src_vco_o,
  output logic                        vdiv_byp_o,
  output logic      [2:0]             vdiv_ratio_o,
  output logic                        vco_pwr_o,
  output logic                        cal_busy_o
);
  import cpmc_pkg::*;
  cpmc_cfg_s    shadow;
  cpmc_cfg_s    active;
  cpmc_nvm_e    nvm_state;
  logic         cal_prev;
  logic [15:0]  cal_cnt;
  logic         xfer;
  cpmc_store_if st ();

  cpmc_store u_store (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .st        (st)
  );

  assign xfer = wr_i && addr_i == `CPMC_OFF_XFER && wdata_i[`CPMC_XFER_BIT];
  assign st.save  = nvm_state == CPMC_SAVE;
  assign st.load  = nvm_state == CPMC_LOAD;
  assign st.wdata = active;

  // reset defaults
  // shadow register writes
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shadow <= '{pwr: `CPMC_PWR_RST, pol: 1'b0, cal: 1'b0,
                  vdiv: `CPMC_VDIV_RST, byp: 1'b0, src: 1'b0};
    end else if (nvm_state == CPMC_LOAD && st.valid) begin
      shadow <= st.rdata;
    end else if (wr_i) begin
      case (addr_i)
        `CPMC_OFF_PLL: begin
          shadow.pwr <= wdata_i[`CPMC_PWR_LSB +: 2];
          shadow.pol <= wdata_i[`CPMC_POL_BIT];
        end
        `CPMC_OFF_CAL:  shadow.cal  <= wdata_i[`CPMC_CAL_BIT];
        `CPMC_OFF_VDIV: shadow.vdiv <= wdata_i[2:0];
        `CPMC_OFF_PATH: begin
          shadow.byp <= wdata_i[`CPMC_BYP_BIT];
          shadow.src <= wdata_i[`CPMC_SRC_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active <= '{pwr: `CPMC_PWR_RST, pol: 1'b0, cal: 1'b0,
                  vdiv: `CPMC_VDIV_RST, byp: 1'b0, src: 1'b0};
    end else if (nvm_state == CPMC_LOAD && st.valid) begin
      active <= st.rdata;
    end else if (xfer) begin
      active <= shadow;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nvm_state <= CPMC_LOAD;
    end else begin
      case (nvm_state)
        CPMC_IDLE: begin
          if (wr_i && addr_i == `CPMC_OFF_NVM) begin
            if (wdata_i[`CPMC_NVM_SAVE_BIT]) begin
              nvm_state <= CPMC_SAVE;
            end else if (wdata_i[`CPMC_NVM_LOAD_BIT]) begin
              nvm_state <= CPMC_LOAD;
            end
          end
        end
        CPMC_SAVE: nvm_state <= CPMC_IDLE;
        CPMC_LOAD: nvm_state <= CPMC_IDLE;
        default:   nvm_state <= CPMC_IDLE;
      endcase
    end
  end

  // calibration start
  // a rising committed calibrate bit starts one run while the committed source bit selects the internal VCO
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_prev <= 1'b0;
      cal_cnt  <= 16'h0000;
    end else begin
      cal_prev <= active.cal;
      if (active.cal && !cal_prev && active.src) begin
        cal_cnt <= 16'(CAL_CYC);
      end else if (cal_cnt != 16'h0000) begin
        cal_cnt <= cal_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_pwr_o    <= `CPMC_PWR_RST;
      pll_on_o     <= 1'b0;
      pfd_neg_o    <= 1'b0;
      src_vco_o    <= 1'b0;
      vdiv_byp_o   <= 1'b0;
      vdiv_ratio_o <= `CPMC_VDIV_RST;
      vco_pwr_o    <= 1'b0;
      cal_busy_o   <= 1'b0;
    end else begin
      pll_pwr_o    <= active.pwr;
      pll_on_o     <= active.pwr == `CPMC_PWR_RUN;
      pfd_neg_o    <= active.pol;
      src_vco_o    <= active.src;
      vdiv_byp_o   <= active.byp;
      vdiv_ratio_o <= active.vdiv;
      vco_pwr_o    <= active.src && active.pwr == `CPMC_PWR_RUN;
      cal_busy_o   <= cal_cnt != 16'h0000;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `CPMC_OFF_PLL:  rdata_o <= {shadow.pol, 5'h00, shadow.pwr};
        `CPMC_OFF_CAL:  rdata_o <= {7'h00, shadow.cal};
        `CPMC_OFF_VDIV: rdata_o <= {5'h00, shadow.vdiv};
        `CPMC_OFF_PATH: rdata_o <= {6'h00, shadow.src, shadow.byp};
        `CPMC_OFF_STAT: rdata_o <= {5'h00, st.valid, active.src,
                                    cal_cnt != 16'h0000};
        default:        rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  property p_commit;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (xfer && nvm_state == CPMC_IDLE) |=> active == $past(shadow);
  endproperty
  a_commit: assert property (p_commit)
    else $error("update did not commit shadow");

  property p_hold;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (!xfer && nvm_state == CPMC_IDLE) |=> $stable(active);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active changed without update");

  property p_pwr;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> pll_on_o == ($past(active.pwr) == 2'h0);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("pll power decode wrong");

  property p_src;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> src_vco_o == $past(active.src);
  endproperty
  a_src: assert property (p_src)
    else $error("source select wrong");

  property p_byp;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> vdiv_byp_o == $past(active.byp);
  endproperty
  a_byp: assert property (p_byp)
    else $error("bypass wrong");

  property p_ratio;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (xfer && nvm_state == CPMC_IDLE) ##1 1'b1 |=>
        vdiv_ratio_o == $past(shadow.vdiv, 2);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("divider ratio not applied");

  property p_pol;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> pfd_neg_o == $past(active.pol);
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity wrong");

  property p_vco_off;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      1'b1 |=> vco_pwr_o == ($past(active.src) &&
                             $past(active.pwr) == 2'h0);
  endproperty
  a_vco_off: assert property (p_vco_off)
    else $error("internal vco powered with clk source");

  property p_cal;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      (active.cal && !cal_prev && active.src) |-> ##2 cal_busy_o;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration did not start");
endmodule

// File: cpmc_host.sv
// host model driving the plain register port of the block
// assumes one clock; signals change just after rising edges
`timescale 1ns/10ps
`include "cpmc_defines.svh"
module cpmc_host (
  input  wire logic                    clk_sys_i,
  input  wire logic [7:0]              rdata_i,
  output logic      [`CPMC_ADDR_W-1:0] addr_o,
  output logic      [7:0]              wdata_o,
  output logic                         wr_o,
  output logic                         rd_o
);
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  // clear and update, then set and update
  task automatic calibrate();
    wr(`CPMC_OFF_CAL, 8'h00);
    wr(`CPMC_OFF_XFER, 8'h01);
    wr(`CPMC_OFF_CAL, 8'h01);
    wr(`CPMC_OFF_XFER, 8'h01);
  endtask
endmodule

// File: clock_path_mode_config_bench.sv
// self-checking bench for the clock path mode configuration top
// assumes the host model speaks the plain register port
`timescale 1ns/10ps
`include "cpmc_defines.svh"
module clock_path_mode_config_bench;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, d;
  logic       wr, rd, pll_on, pfd_neg, src, byp, vco_pwr, busy;
  logic [1:0] pwr;
  logic [2:0] vdiv;
  int         err_count = 0;
  int         cmp_count = 0;
  int         n;
  // row 0 keeps the divider with the internal source; rows 1 and 2 bypass it with CLK; row 3 holds the reset defaults
  logic [7:0] tab [4][3] = '{'{8'h80, 8'h02, 8'h05},
    '{8'h01, 8'h01, 8'h00}, '{8'h00, 8'h01, 8'h03},
    '{8'h01, 8'h00, 8'h00}};
  always #20 clk_sys_i = ~clk_sys_i;
  cpmc_top #(.CAL_CYC(4)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .pll_pwr_o(pwr), .pll_on_o(pll_on), .pfd_neg_o(pfd_neg),
    .src_vco_o(src), .vdiv_byp_o(byp), .vdiv_ratio_o(vdiv),
    .vco_pwr_o(vco_pwr), .cal_busy_o(busy));
  cpmc_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic check(input string nm, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic outs(input int i);
    check("pll_pwr_o", 8'(pwr), 8'(tab[i][0][1:0]));
    check("pll_on_o", 8'(pll_on), 8'(tab[i][0][1:0] == 2'h0));
    check("pfd_neg_o", 8'(pfd_neg), 8'(tab[i][0][7]));
    check("src_vco_o", 8'(src), 8'(tab[i][1][1]));
    check("vdiv_byp_o", 8'(byp), 8'(tab[i][1][0]));
    check("vdiv_ratio_o", 8'(vdiv), tab[i][2]);
    check("vco_pwr_o", 8'(vco_pwr),
          8'(tab[i][1][1] && tab[i][0][1:0] == 2'h0));
  endtask
  task automatic load(input int i);
    host.wr(`CPMC_OFF_PLL, tab[i][0]);
    host.wr(`CPMC_OFF_PATH, tab[i][1]);
    host.wr(`CPMC_OFF_VDIV, tab[i][2]);
    #1;
  endtask
  task automatic commit();
    host.wr(`CPMC_OFF_XFER, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    outs(3);
    host.rd(`CPMC_OFF_PLL, d);
    check("reg_pll", d, 8'h01);
    host.rd(10'h123, d);
    check("unmapped", d, 8'h00);
    $display("test reset done");
    for (n = 0; n < 4; n++) begin
      load(n);
      outs((n + 3) % 4);
      commit();
      outs(n);
    end
    $display("test modes done");
    load(0);
    commit();
    repeat (2) begin
      host.calibrate();
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
        @(posedge clk_sys_i);
        #1;
        n++;
      end
      check("cal_start", 8'(busy), 8'h01);
      n = 0;
      while (busy === 1'b1 && n < 20) begin
        @(posedge clk_sys_i);
        #1;
        n++;
      end
      check("cal_cycles", 8'(n), 8'h04);
    end
    $display("test calibration done");
    host.wr(`CPMC_OFF_NVM, 8'h01);
    load(3);
    commit();
    outs(3);
    host.wr(`CPMC_OFF_NVM, 8'h02);
    n = 0;
    while (src !== 1'b1 && n < 10) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    outs(0);
    host.rd(`CPMC_OFF_XFER, d);
    check("xfer_read", d, 8'h00);
    host.rd(`CPMC_OFF_STAT, d);
    check("status", d, 8'h06);
    // a reset in mid-run must bring the saved configuration back
    load(3);
    commit();
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    outs(0);
    host.rd(`CPMC_OFF_PLL, d);
    check("reg_pll_restored", d, tab[0][0]);
    $display("test store done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    conclude();
  end
endmodule
